// *** pdwr_host.sv ***
// pdwr_host.sv: host controller driving a 12-bit converter parallel port
// assumes: device pins wired straight to the PDB/CS/RW ports; the pad
// merges PDB_O and PDB_OE with the device's drive
//
// Summary of operation
// - select low frames every transfer
// - write holds direction low, drives code
// - readback holds direction high, device drives
// - twelve bit bus, bit 11 is MSB
`timescale 1ns/1ns
`include "pdwr_map.svh"
module pdwr_host
  import pdwr_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic WR_REQ,
  input wire logic [`PDWR_DATA_MSB:0] WR_CODE,
  input wire logic RD_REQ,
  output logic REQ_READY,
  output logic [`PDWR_DATA_MSB:0] RD_CODE,
  output logic RD_VALID,
  output logic WR_DONE,
  output logic CS_N,
  output logic RW,
  output logic [`PDWR_DATA_MSB:0] PDB_O,
  output logic PDB_OE,
  input wire logic [`PDWR_DATA_MSB:0] PDB_I
);
  //////////////////////////////////////////////////////////////////////////
  typedef struct packed
  {
    pdwr_state_t st;
    logic [`PDWR_CNT_W-1:0] cnt;
    logic cs_n;
    logic rw;
    logic oe;
    logic [`PDWR_DATA_MSB:0] wdata;
    logic [`PDWR_DATA_MSB:0] rdata;
    logic rvalid;
    logic wdone;
    logic [`PDWR_DATA_MSB:0] rprev;
    logic [1:0] retry;
  } pdwr_host_t;
  pdwr_host_t s_q;
  pdwr_host_t s_d;
  logic [`PDWR_DATA_MSB:0] pdb_sync;
  logic rd_settled;
  //////////////////////////////////////////////////////////////////////////
  // readback data is asynchronous to REF_CLK
  pdwr_sync #(.W(`PDWR_DATA_W)) u_sync
  (
    .clk(REF_CLK),
    .rst(RST),
    .din(PDB_I),
    .dout(pdb_sync)
  );
  //////////////////////////////////////////////////////////////////////////
  // a word caught while the pins change differs between two samples;
  // a bus that never settles is taken after three retries
  always_comb
  begin
    rd_settled = (pdb_sync == s_q.rprev) || (s_q.retry == 2'h3);
  end
  //////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.wdone = 1'b0;
    case (s_q.st)
      PDWR_IDLE:
      begin
        s_d.cs_n = 1'b1;
        s_d.oe = 1'b0;
        s_d.rw = 1'b0;
        // write has priority when both are asked together
        if (WR_REQ)
        begin
          s_d.rw = 1'b0;
          s_d.oe = 1'b1;
          s_d.wdata = WR_CODE;
          s_d.cs_n = 1'b0;
          s_d.cnt = `PDWR_CNT_W'(`PDWR_CS_LOW_CYC - 1);
          s_d.st = PDWR_WR_LOW;
        end
        else if (RD_REQ)
        begin
          s_d.rw = 1'b1;
          s_d.oe = 1'b0;
          s_d.cnt = `PDWR_CNT_W'(`PDWR_RW_SETUP_CYC - 1);
          s_d.st = PDWR_RD_SETUP;
        end
      end
      PDWR_WR_LOW:
      begin
        // pin levels restated per state so a bad mix heals in one cycle
        s_d.cs_n = 1'b0;
        s_d.rw = 1'b0;
        s_d.oe = 1'b1;
        if (s_q.cnt == '0)
        begin
          s_d.cs_n = 1'b1;
          s_d.st = PDWR_WR_END;
        end
        else
          s_d.cnt = s_q.cnt - 1'b1;
      end
      PDWR_WR_END:
      begin
        // data held one cycle past the rising edge for hold time
        s_d.cs_n = 1'b1;
        s_d.rw = 1'b0;
        s_d.oe = 1'b0;
        s_d.wdone = 1'b1;
        s_d.cnt = `PDWR_CNT_W'(`PDWR_GAP_CYC - 1);
        s_d.st = PDWR_GAP;
      end
      PDWR_RD_SETUP:
      begin
        s_d.rw = 1'b1;
        s_d.oe = 1'b0;
        if (s_q.cnt == '0)
        begin
          s_d.cs_n = 1'b0;
          s_d.retry = 2'h0;
          s_d.cnt = `PDWR_CNT_W'(`PDWR_ACCESS_CYC + 1);
          s_d.st = PDWR_RD_LOW;
        end
        else
          s_d.cnt = s_q.cnt - 1'b1;
      end
      PDWR_RD_LOW:
      begin
        s_d.cs_n = 1'b0;
        s_d.rw = 1'b1;
        s_d.oe = 1'b0;
        s_d.rprev = pdb_sync;
        // sample after access time plus two synchroniser stages
        if (s_q.cnt != '0)
          s_d.cnt = s_q.cnt - 1'b1;
        else if (rd_settled)
        begin
          s_d.rdata = pdb_sync;
          s_d.rvalid = 1'b1;
          s_d.cs_n = 1'b1;
          s_d.cnt = `PDWR_CNT_W'(`PDWR_GAP_CYC - 1);
          s_d.st = PDWR_GAP;
        end
        else
          s_d.retry = s_q.retry + 2'h1;
      end
      PDWR_GAP:
      begin
        // select high time and bus relinquish before any next drive
        s_d.cs_n = 1'b1;
        s_d.oe = 1'b0;
        if (s_q.cnt == '0)
        begin
          s_d.rw = 1'b0;
          s_d.st = PDWR_IDLE;
        end
        else
          s_d.cnt = s_q.cnt - 1'b1;
      end
      default:
      begin
        s_d.st = PDWR_IDLE;
        s_d.cs_n = 1'b1;
        s_d.oe = 1'b0;
        s_d.rw = 1'b0;
        s_d.cnt = '0;
        s_d.retry = 2'h0;
      end
    endcase
  end
  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      s_q.st <= PDWR_IDLE;
      s_q.cnt <= '0;
      s_q.cs_n <= 1'b1;
      s_q.rw <= 1'b0;
      s_q.oe <= 1'b0;
      s_q.wdata <= '0;
      s_q.rdata <= '0;
      s_q.rvalid <= 1'b0;
      s_q.wdone <= 1'b0;
      s_q.rprev <= '0;
      s_q.retry <= 2'h0;
    end
    else
      s_q <= s_d;
  end
  //////////////////////////////////////////////////////////////////////////
  assign REQ_READY = (s_q.st == PDWR_IDLE);
  assign RD_CODE = s_q.rdata;
  assign RD_VALID = s_q.rvalid;
  assign WR_DONE = s_q.wdone;
  assign CS_N = s_q.cs_n;
  assign RW = s_q.rw;
  assign PDB_O = s_q.wdata;
  assign PDB_OE = s_q.oe;
endmodule

// *** pdwr_map.svh ***
// pdwr_map.svh: field positions and timing counts for the host port
// assumes: included by bare name; REF_CLK runs at 50 MHz
`ifndef PDWR_MAP_SVH
`define PDWR_MAP_SVH
`define PDWR_CLK_PERIOD_NS 20
`define PDWR_DATA_W 12
`define PDWR_DATA_MSB 11
`define PDWR_DATA_LSB 0
// least and greatest times, ns, as printed for the lower supply range (worst case)
`define PDWR_T_CS_LOW_NS 10
`define PDWR_T_DATA_SETUP_NS 6
`define PDWR_T_RW_HIGH_TO_CS_NS 5
`define PDWR_T_CS_HIGH_NS 9
`define PDWR_T_ACCESS_MAX_NS 40
`define PDWR_T_RELINQUISH_MAX_NS 10
// cycles, least and greatest times rounded up, never below one
`define PDWR_CYC(ns) (((ns) + `PDWR_CLK_PERIOD_NS - 1) / `PDWR_CLK_PERIOD_NS)
`define PDWR_CS_LOW_CYC (`PDWR_CYC(`PDWR_T_CS_LOW_NS) + \
  `PDWR_CYC(`PDWR_T_DATA_SETUP_NS))
`define PDWR_ACCESS_CYC (`PDWR_CYC(`PDWR_T_ACCESS_MAX_NS) + 1)
`define PDWR_RW_SETUP_CYC `PDWR_CYC(`PDWR_T_RW_HIGH_TO_CS_NS)
`define PDWR_GAP_CYC (`PDWR_CYC(`PDWR_T_CS_HIGH_NS) + \
  `PDWR_CYC(`PDWR_T_RELINQUISH_MAX_NS))
`define PDWR_CNT_W 4
`endif

// *** pdwr_pkg.sv ***
// pdwr_pkg.sv: types for the parallel converter host port
// assumes: nothing beyond the map header
package pdwr_pkg;
  typedef enum logic [5:0] {
    PDWR_IDLE = 6'h01,
    PDWR_WR_LOW = 6'h02,
    PDWR_RD_SETUP = 6'h04,
    PDWR_RD_LOW = 6'h08,
    PDWR_GAP = 6'h10,
    PDWR_WR_END = 6'h20
  } pdwr_state_t;
endpackage

// *** pdwr_sync.sv ***
// pdwr_sync.sv: two flop synchroniser for a bus of pin inputs
// assumes: inputs are asynchronous to clk
`timescale 1ns/1ns
module pdwr_sync #(parameter int W = 1)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed
  {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } pdwr_sync_t;
  pdwr_sync_t s_q;
  pdwr_sync_t s_d;
  always_comb
  begin
    s_d.meta = din;
    s_d.sync = s_q.meta;
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end
  assign dout = s_q.sync;
endmodule

// *** pdwr_asserts.sv ***
// checker: host side timing relations at the port
// assumes: bound to pdwr_host, one clock domain
`timescale 1ns/1ns
module pdwr_asserts (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CS_N,
  input wire logic RW,
  input wire logic PDB_OE,
  input wire logic [11:0] PDB_O,
  input wire logic RD_VALID,
  input wire logic WR_DONE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  a_drive_dir: assert property (PDB_OE |-> !RW)
    else $error("bus driven during read");
  a_rw_framed: assert property (!CS_N && $past(!CS_N) |-> $stable(RW))
    else $error("direction moved in frame");
  a_wr_hold: assert property ($rose(CS_N) && !RW |->
    PDB_OE && $stable(PDB_O))
    else $error("data not held at select rise");
  a_wr_pulse: assert property ($fell(CS_N) && !RW |-> ##2 $rose(CS_N))
    else $error("write select low time wrong");
  a_rd_bounded: assert property ($fell(CS_N) && RW |->
    ##[5:8] $rose(CS_N))
    else $error("read frame not ended in time");
  a_rd_setup: assert property ($fell(CS_N) && RW |-> $past(RW))
    else $error("direction late for read");
  a_rd_frame: assert property ($rose(RD_VALID) |-> $rose(CS_N) && RW)
    else $error("read result outside frame");
  a_wr_commit: assert property (WR_DONE |-> $past(CS_N, 2) == 1'b0)
    else $error("write done without frame");
  c_write: cover property (WR_DONE);
  c_read: cover property (RD_VALID);
  c_rd_start: cover property ($fell(CS_N) && RW);
endmodule
bind pdwr_host pdwr_asserts u_chk (.REF_CLK(REF_CLK), .RST(RST),
  .CS_N(CS_N), .RW(RW), .PDB_OE(PDB_OE), .PDB_O(PDB_O),
  .RD_VALID(RD_VALID), .WR_DONE(WR_DONE));

// *** pdwr_dev_model.sv ***
// partner: converter register behind the parallel port
// assumes: pins wired direct, no pull on the data bus
`timescale 1ns/1ns
module pdwr_dev_model (
  input wire logic cs_n,
  input wire logic rw,
  input wire logic host_oe,
  input wire logic [11:0] host_d,
  output logic [11:0] pin,
  output logic [11:0] dac_q
);
  initial dac_q = 12'h000;
  // loads at select rise only, never while low
  always @(posedge cs_n)
    if (rw === 1'b0 && $time > 0)
      dac_q <= pin;
  // released bus shows inverse so a late sample fails
  assign pin = host_oe ? host_d : (!cs_n && rw) ? dac_q : ~dac_q;
endmodule

// *** tb_top.sv ***
// bench: writes and readbacks through the host controller
// assumes: device model on the pins
`timescale 1ns/1ns
module tb_top;
  logic ref_clk, rst, wr_req, rd_req, rdy, rd_valid, wr_done, cs_n, rw, oe;
  logic [11:0] wr_code, rd_code, pdb_o, pin, dac_q;
  int error_cnt, num_checks, n;
  pdwr_host uut (.REF_CLK(ref_clk), .RST(rst), .WR_REQ(wr_req),
    .WR_CODE(wr_code), .RD_REQ(rd_req), .REQ_READY(rdy), .RD_CODE(rd_code),
    .RD_VALID(rd_valid), .WR_DONE(wr_done), .CS_N(cs_n), .RW(rw),
    .PDB_O(pdb_o), .PDB_OE(oe), .PDB_I(pin));
  pdwr_dev_model dev (.cs_n(cs_n), .rw(rw), .host_oe(oe), .host_d(pdb_o),
    .pin(pin), .dac_q(dac_q));
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task chk(input logic ok);
    num_checks++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t mismatch", $time);
    end
  endtask
  task results;
    $display("errors %0d checks %0d", error_cnt, num_checks);
    if (error_cnt == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // a wait that runs out counts as a mismatch and ends the run
  task give_up;
    error_cnt++;
    $display("CHECK FAILED %0t timeout", $time);
    results();
  endtask
  // takes one request, then waits bounded for its answer
  task xfer(input logic wr, input logic [11:0] code);
    @(posedge ref_clk);
    wr_code <= code;
    wr_req <= wr;
    rd_req <= !wr;
    @(posedge ref_clk);
    wr_req <= 1'b0;
    rd_req <= 1'b0;
    for (n = 0; n < 20 && wr_done !== 1'b1 && rd_valid !== 1'b1; n++)
    begin
      @(negedge ref_clk);
      if (wr && !cs_n)
        chk(dac_q !== code);
      if (!cs_n && rw)
        chk(oe === 1'b0);
    end
    if (n == 20)
      give_up();
    chk(wr ? dac_q === code : rd_code === code);
    for (n = 0; n < 20 && rdy !== 1'b1; n++)
      @(negedge ref_clk);
    if (n == 20)
      give_up();
    chk(rdy === 1'b1 && cs_n === 1'b1 && oe === 1'b0);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task t_reset;
    chk(cs_n === 1'b1 && oe === 1'b0 && rdy === 1'b1);
    xfer(1'b0, 12'h000);
  endtask
  task t_bits;
    xfer(1'b1, 12'h800);
    xfer(1'b0, 12'h800);
    xfer(1'b1, 12'h001);
    xfer(1'b0, 12'h001);
  endtask
  task t_back_to_back;
    xfer(1'b1, 12'hA5C);
    xfer(1'b1, 12'h5A3);
    xfer(1'b0, 12'h5A3);
  endtask
  // write wins when both requests come at one edge
  task t_priority;
    @(posedge ref_clk);
    wr_code <= 12'h3C7;
    wr_req <= 1'b1;
    rd_req <= 1'b1;
    @(posedge ref_clk);
    wr_req <= 1'b0;
    rd_req <= 1'b0;
    @(negedge ref_clk);
    chk(rw === 1'b0 && oe === 1'b1);
    for (n = 0; n < 20 && rdy !== 1'b1; n++)
    begin
      @(negedge ref_clk);
      chk(rd_valid !== 1'b1);
    end
    if (n == 20)
      give_up();
    chk(dac_q === 12'h3C7);
  endtask
  initial
  begin
    rst = 1'b1;
    wr_req = 1'b0;
    rd_req = 1'b0;
    wr_code = 12'h000;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    t_reset();
    t_bits();
    t_back_to_back();
    t_priority();
    results();
  end
endmodule
